/* File: logic/phy_mgmt_pkg.sv */
/*
  Package for the PHY management access block: register map, field layout,
  clock divider table, frame constants and the carrier structs.
  Assumes a 32-bit AXI4-Lite register bus and a single system clock.
*/
package phy_mgmt_pkg;

  // Register byte offsets.
  localparam logic [7:0] CMD_OFFSET = 8'h10;
  localparam logic [7:0] DATA_OFFSET = 8'h14;

  // Command register fields.
  localparam int BUSY_BIT = 0;
  localparam int WRITE_BIT = 1;
  localparam int RANGE_LSB = 2;
  localparam int RANGE_MSB = 4;
  localparam int REGIDX_LSB = 6;
  localparam int REGIDX_MSB = 10;
  localparam int PHYSEL_LSB = 11;
  localparam int PHYSEL_MSB = 15;
  localparam int DATA_MSB = 15;

  // Reset values.
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // Clock range codes and their divide ratios.
  localparam logic [2:0] RANGE_60_100 = 3'h0;
  localparam logic [2:0] RANGE_100_150 = 3'h1;
  localparam logic [2:0] RANGE_20_35 = 3'h2;
  localparam logic [2:0] RANGE_35_60 = 3'h3;
  localparam logic [2:0] RANGE_150_168 = 3'h4;
  localparam logic [7:0] DIV_60_100 = 8'h2a;
  localparam logic [7:0] DIV_100_150 = 8'h3e;
  localparam logic [7:0] DIV_20_35 = 8'h10;
  localparam logic [7:0] DIV_35_60 = 8'h1a;
  localparam logic [7:0] DIV_150_168 = 8'h66;

  // Frame layout: 32 preamble bits, then 32 bits of start, opcode, addresses,
  // turnaround and data.
  localparam logic [6:0] PREAMBLE_BITS = 7'h20;
  localparam logic [6:0] FRAME_BITS = 7'h40;
  localparam logic [6:0] TA_FIRST_BIT = 7'h2e;
  localparam logic [6:0] DATA_FIRST_BIT = 7'h30;
  localparam logic [1:0] START_CODE = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] TA_WRITE = 2'h2;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Command register contents.
  typedef struct packed {
    logic [4:0] phySel;
    logic [4:0] regIndex;
    logic [2:0] clockRange;
    logic write;
    logic busy;
  } command_s;

  // Management pins: clock out, data out and data enable.
  typedef struct packed {
    logic mdc;
    logic mdioOut;
    logic mdioOe;
  } mgmt_pins_s;

endpackage

/* File: logic/phy_mgmt_access.sv */
/*
  PHY management access block: an AXI4-Lite slave holding the command and
  data registers and a serial management engine driving one PHY frame per access.
  Assumes the management data pin is resolved outside from mdioOut and mdioOe,
  and that AXI masters keep valid and payload steady until accepted.
*/
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

module phy_mgmt_access (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic mdioIn,
  output phy_mgmt_pkg::mgmt_pins_s mgmtPins
);

  // Link sequencer states: waiting, shifting the frame, one cycle to wrap up.
  typedef enum logic [1:0] {IDLE, SHIFT, FINISH} mgmt_state_e;

  // Register state, link state and the held halves of a bus write.
  phy_mgmt_pkg::command_s command_reg;
  logic [15:0] data_reg;
  mgmt_state_e state_reg;
  logic [7:0] divCount_reg;
  logic [7:0] divRatio;
  logic [6:0] bitCount_reg;
  logic [31:0] shift_reg;
  logic [15:0] readShift_reg;
  logic mdc_reg;
  logic mdioOut_reg;
  logic mdioOe_reg;
  logic [7:0] awaddr_reg;
  logic awHeld_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wHeld_reg;
  logic doWrite;
  logic writeCmd;
  logic writeData;
  logic startAccess;
  logic mdcRise;
  logic mdcFall;
  logic readDone;
  logic [31:0] frameWord;
  logic lastPreambleBit;
  logic lastFrameBit;
  logic [31:0] readWord;
  logic readHit;

  // Divide ratio from the clock range code; reserved codes fall back to the largest.
  always_comb begin
    case (command_reg.clockRange)
      phy_mgmt_pkg::RANGE_60_100: divRatio = phy_mgmt_pkg::DIV_60_100;
      phy_mgmt_pkg::RANGE_100_150: divRatio = phy_mgmt_pkg::DIV_100_150;
      phy_mgmt_pkg::RANGE_20_35: divRatio = phy_mgmt_pkg::DIV_20_35;
      phy_mgmt_pkg::RANGE_35_60: divRatio = phy_mgmt_pkg::DIV_35_60;
      phy_mgmt_pkg::RANGE_150_168: divRatio = phy_mgmt_pkg::DIV_150_168;
      default: divRatio = phy_mgmt_pkg::DIV_150_168;
    endcase
  end

  // Write address and data channels are caught independently in any order.
  assign awready = !awHeld_reg;
  assign wready = !wHeld_reg;
  assign doWrite = awHeld_reg && wHeld_reg && !bvalid;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (awvalid && awready) begin
      awHeld_reg <= 1'b1;
      awaddr_reg <= awaddr;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wHeld_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else if (wvalid && wready) begin
      wHeld_reg <= 1'b1;
      wdata_reg <= wdata;
      wstrb_reg <= wstrb;
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end
  end

  // Write response: OKAY for the two registers, SLVERR elsewhere.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bvalid <= 1'b0;
      bresp <= phy_mgmt_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= (writeCmd || writeData) ? phy_mgmt_pkg::RESP_OKAY : phy_mgmt_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  assign writeCmd = doWrite && awaddr_reg[7:2] == phy_mgmt_pkg::CMD_OFFSET[7:2];
  assign writeData = doWrite && awaddr_reg[7:2] == phy_mgmt_pkg::DATA_OFFSET[7:2];
  // Writes to the command register while busy are dropped so a live frame keeps its fields.
  assign startAccess = writeCmd && !command_reg.busy && wstrb_reg[0]
    && wdata_reg[phy_mgmt_pkg::BUSY_BIT];

  // Command register; the low byte and the second byte take their own strobes.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      command_reg <= phy_mgmt_pkg::CMD_RESET[14:0];
    end else if (writeCmd && !command_reg.busy) begin
      if (wstrb_reg[0]) begin
        command_reg.busy <= wdata_reg[phy_mgmt_pkg::BUSY_BIT];
        command_reg.write <= wdata_reg[phy_mgmt_pkg::WRITE_BIT];
        command_reg.clockRange <= wdata_reg[phy_mgmt_pkg::RANGE_MSB:phy_mgmt_pkg::RANGE_LSB];
        command_reg.regIndex[1:0] <= wdata_reg[7:phy_mgmt_pkg::REGIDX_LSB];
      end
      if (wstrb_reg[1]) begin
        command_reg.regIndex[4:2] <= wdata_reg[phy_mgmt_pkg::REGIDX_MSB:8];
        command_reg.phySel <= wdata_reg[phy_mgmt_pkg::PHYSEL_MSB:phy_mgmt_pkg::PHYSEL_LSB];
      end
    end else if (state_reg == FINISH) begin
      command_reg.busy <= 1'b0;
    end
  end

  // Data register: software writes while idle; a finished read loads it first.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      data_reg <= phy_mgmt_pkg::DATA_RESET;
    end else if (readDone) begin
      data_reg <= readShift_reg;
    end else if (writeData && !command_reg.busy) begin
      if (wstrb_reg[0]) begin
        data_reg[7:0] <= wdata_reg[7:0];
      end
      if (wstrb_reg[1]) begin
        data_reg[15:8] <= wdata_reg[phy_mgmt_pkg::DATA_MSB:8];
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  assign arready = !rvalid;

  // Read word and response for the presented address; unmapped offsets read zero.
  always_comb begin
    readWord = 32'h00000000;
    readHit = 1'b1;
    if (araddr[7:2] == phy_mgmt_pkg::CMD_OFFSET[7:2]) begin
      readWord = {16'h0000, command_reg.phySel, command_reg.regIndex, 1'b0,
        command_reg.clockRange, command_reg.write, command_reg.busy};
    end else if (araddr[7:2] == phy_mgmt_pkg::DATA_OFFSET[7:2]) begin
      readWord = {16'h0000, data_reg};
    end else begin
      readHit = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= phy_mgmt_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= readWord;
      rresp <= readHit ? phy_mgmt_pkg::RESP_OKAY : phy_mgmt_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Clock divider: low half then high half of each management clock period.
  assign mdcFall = state_reg == SHIFT && divCount_reg == divRatio - 8'h01;
  assign mdcRise = state_reg == SHIFT && divCount_reg == (divRatio >> 1) - 8'h01;

  // Divider count: one full count per bit; the ratio cannot move mid-frame as
  // command writes are dropped while busy.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      divCount_reg <= 8'h00;
    end else if (state_reg != SHIFT || mdcFall) begin
      divCount_reg <= 8'h00;
    end else begin
      divCount_reg <= divCount_reg + 8'h01;
    end
  end

  // Management clock: low in the first half of each bit period, high in the second.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mdc_reg <= 1'b0;
    end else if (state_reg != SHIFT) begin
      mdc_reg <= 1'b0;
    end else if (mdcFall) begin
      mdc_reg <= 1'b0;
    end else if (mdcRise) begin
      mdc_reg <= 1'b1;
    end
  end

  // Frame sequencer: one bit per management clock period, changed on the falling edge.
  assign frameWord = {phy_mgmt_pkg::START_CODE,
    command_reg.write ? phy_mgmt_pkg::OP_WRITE : phy_mgmt_pkg::OP_READ,
    command_reg.phySel, command_reg.regIndex, phy_mgmt_pkg::TA_WRITE, data_reg};
  assign readDone = state_reg == FINISH && !command_reg.write;

  // Bit positions at which the line leaves the preamble and ends the frame.
  assign lastPreambleBit = bitCount_reg == phy_mgmt_pkg::PREAMBLE_BITS - 7'h01;
  assign lastFrameBit = bitCount_reg == phy_mgmt_pkg::FRAME_BITS - 7'h01;

  // Sequencer state: a start leaves idle, the last falling clock ends the frame.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= IDLE;
    end else begin
      case (state_reg)
        IDLE: begin
          if (startAccess) begin
            state_reg <= SHIFT;
          end
        end
        SHIFT: begin
          if (mdcFall && lastFrameBit) begin
            state_reg <= FINISH;
          end
        end
        FINISH: state_reg <= IDLE;
        default: state_reg <= IDLE;
      endcase
    end
  end

  // Bit counter: index of the bit now on the line, stepped at each falling clock.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bitCount_reg <= 7'h00;
    end else if (state_reg != SHIFT) begin
      bitCount_reg <= 7'h00;
    end else if (mdcFall) begin
      bitCount_reg <= bitCount_reg + 7'h01;
    end
  end

  // Frame word: taken as the preamble ends, so the data word is read at that moment.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= 32'h00000000;
    end else if (mdcFall && lastPreambleBit) begin
      shift_reg <= frameWord;
    end else if (mdcFall) begin
      shift_reg <= {shift_reg[30:0], 1'b0};
    end
  end

  // Data out: preamble ones, then the frame word MSB first, changed with the falling clock.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mdioOut_reg <= 1'b0;
    end else if (state_reg == IDLE && startAccess) begin
      mdioOut_reg <= 1'b1;
    end else if (mdcFall && !lastFrameBit) begin
      if (bitCount_reg < phy_mgmt_pkg::PREAMBLE_BITS - 7'h01) begin
        mdioOut_reg <= 1'b1;
      end else if (lastPreambleBit) begin
        mdioOut_reg <= frameWord[31];
      end else begin
        mdioOut_reg <= shift_reg[30];
      end
    end else if (state_reg != SHIFT) begin
      mdioOut_reg <= 1'b0;
    end
  end

  // Data enable: a read hands the line to the PHY from the first turnaround bit.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mdioOe_reg <= 1'b0;
    end else if (state_reg == IDLE && startAccess) begin
      mdioOe_reg <= 1'b1;
    end else if (mdcFall && !lastFrameBit) begin
      mdioOe_reg <= command_reg.write
        || bitCount_reg < phy_mgmt_pkg::TA_FIRST_BIT - 7'h01;
    end else if (state_reg != SHIFT) begin
      mdioOe_reg <= 1'b0;
    end
  end

  // Read data is sampled on the rising management clock during the data bits.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      readShift_reg <= 16'h0000;
    end else if (mdcRise && bitCount_reg >= phy_mgmt_pkg::DATA_FIRST_BIT) begin
      readShift_reg <= {readShift_reg[14:0], mdioIn};
    end
  end

  // Pin outputs come straight from flip-flops so the PHY never sees a glitch.
  assign mgmtPins.mdc = mdc_reg;
  assign mgmtPins.mdioOut = mdioOut_reg;
  assign mgmtPins.mdioOe = mdioOe_reg;

endmodule

/* File: tb/phy_mgmt_checker_assertions.sv */
/*
  Checker for the PHY management access block, watching its ports only.
  Assumes one clock domain with an active-low asynchronous reset.
*/
`timescale 1ns/100ps

module phy_mgmt_checker (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire phy_mgmt_pkg::mgmt_pins_s mgmtPins
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Half periods of the divided clock lie between 8 and 51 system clocks.
  chk_high_phase: assert property ($rose(mgmtPins.mdc) |-> mgmtPins.mdc [*8])
    else $error("Management clock high phase too short.");
  chk_low_phase: assert property ($fell(mgmtPins.mdc) |-> !mgmtPins.mdc [*8])
    else $error("Management clock low phase too short.");
  chk_high_bound: assert property ($rose(mgmtPins.mdc) |-> ##[1:51] !mgmtPins.mdc)
    else $error("Management clock high phase too long.");
  // A frame opens with the line driven to one and releases it while the clock is low.
  chk_preamble_one: assert property ($rose(mgmtPins.mdioOe) |-> mgmtPins.mdioOut)
    else $error("Frame does not open with a one.");
  chk_release_low: assert property ($fell(mgmtPins.mdioOe) |-> !mgmtPins.mdc)
    else $error("Data line released while clock high.");
  // Bus answers come in time and stand until taken.
  chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
    else $error("Write response missing.");
  chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write response dropped early.");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("Read response late.");
  chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("Read data changed while waiting.");

  cover property ($rose(mgmtPins.mdioOe));
  cover property (rvalid && rresp == 2'h2);
  cover property (bvalid && bresp == 2'h0);
endmodule

bind phy_mgmt_access phy_mgmt_checker chk (.clock(clock), .arst_n(arst_n), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .mgmtPins(mgmtPins));

/* File: tb/phy_mgmt_partner.sv */
/*
  Behavioural PHY on the management line: decodes each frame and answers reads.
  Assumes a pull-up on the data line and frames of 64 bits.
*/
`timescale 1ns/100ps

module phy_mgmt_partner (
  input wire logic arst_n,
  input wire phy_mgmt_pkg::mgmt_pins_s pins,
  output logic mdioIn,
  output logic done,
  output logic [27:0] frame
);
  int n;
  logic [63:0] sh;
  logic rd;
  logic drv;
  logic drvBit;
  logic [15:0] val;

  // Wire level: block drive, else PHY drive, else the pull-up.
  assign mdioIn = pins.mdioOe ? pins.mdioOut : (drv ? drvBit : 1'b1);

  // Samples each bit at the rising clock and reports the fields after 64 bits.
  always @(posedge pins.mdc or negedge arst_n) begin
    if (!arst_n) begin
      n = 0;
      done = 1'b0;
    end else begin
      sh = {sh[62:0], mdioIn};
      n = n + 1;
      done = 1'b0;
      if (n == 64) begin
        frame = {sh[29:28], sh[27:18], sh[15:0]};
        done = 1'b1;
        n = 0;
      end
    end
  end

  // Read answer: turnaround zero then 16 bits, MSB first, changed at the falling clock.
  always @(negedge pins.mdc or negedge arst_n) begin
    if (!arst_n) begin
      drv = 1'b0;
      rd = 1'b0;
    end else begin
      if (n == 46) begin
        rd = (sh[11:10] == 2'h2);
        val = {3'h5, sh[9:0], 3'h3};
      end
      drv = rd && n >= 47;
      drvBit = (n == 47) ? 1'b0 : val[63 - n];
    end
  end
endmodule

/* File: tb/phy_management_access_tb_top.sv */
/*
  Self-checking bench: AXI4-Lite master, PHY partner, queued expectations.
  Assumes a 100 MHz clock and the partner's fixed read values.
*/
`timescale 1ns/100ps

module phy_management_access_tb_top;
  logic clock, arst_n, awvalid, wvalid, bready, arvalid, rready, done;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, mdioIn, mdcD;
  logic [27:0] frame;
  logic [3:0] wstrb, ws;
  logic [34:0] rq[$];
  logic [27:0] fq[$];
  phy_mgmt_pkg::mgmt_pins_s mgmtPins;
  int n_fail, n_checks, cyc, pc, lastPer;
  int divTab[5] = '{42, 62, 16, 26, 102};

  phy_mgmt_access DUT (.clock(clock), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .mdioIn(mdioIn), .mgmtPins(mgmtPins));
  phy_mgmt_partner phy (.arst_n(arst_n), .pins(mgmtPins), .mdioIn(mdioIn), .done(done),
    .frame(frame));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (e !== s) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Write: address and data offered together, each released when taken.
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= ws;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && w)) begin
      @(posedge clock);
      if (awvalid && awready) begin aw = 1; awvalid <= 0; end
      if (wvalid && wready) begin w = 1; wvalid <= 0; end
    end
    do @(posedge clock); while (!bvalid);
    bready <= 0;
    chk("bresp", er, bresp);
    @(posedge clock);
  endtask

  // Read: the expectation is queued; c low means the value is only polled.
  task automatic axiRead(input logic [7:0] a, input logic c, input logic [31:0] e,
    input logic [1:0] er);
    rq.push_back({c, er, e});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clock); while (!arready);
    arvalid <= 0;
    do @(posedge clock); while (!rvalid);
    rd = rdata;
    rready <= 0;
    @(posedge clock);
  endtask

  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end

  // Compares read answers and decoded frames with the oldest notes.
  always @(posedge clock) begin
    if (rvalid && rready) begin
      if (rq[0][34]) chk("rdata", rq[0][31:0], rdata);
      if (rq[0][34]) chk("rresp", rq[0][33:32], rresp);
      void'(rq.pop_front());
    end
  end
  always @(posedge done) begin
    if (fq.size() == 0) chk("frame count", 0, 1);
    else chk("frame", fq.pop_front(), frame);
  end

  // Divided clock period meter and timeout.
  always @(posedge clock) begin
    pc <= pc + 1;
    mdcD <= mgmtPins.mdc;
    if (mgmtPins.mdc && !mdcD) begin lastPer <= pc; pc <= 1; end
    cyc++;
    if (cyc == 40000) begin n_fail++; close_out(); end
  end

  initial begin
    logic [4:0] phyS, regS;
    logic [15:0] d, e;
    logic wr;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    ws = 4'hf;
    wstrb = 4'hf;
    arst_n = 0;
    void'($urandom(32'h0b11));
    repeat (16) @(posedge clock);
    arst_n <= 1;
    @(posedge clock);
    axiRead(8'h10, 1, 32'h0, 2'h0);
    axiRead(8'h14, 1, 32'h0, 2'h0);
    axiRead(8'h20, 1, 32'h0, 2'h2);
    axiWrite(8'h20, 32'h1, 2'h2);
    ws = 4'h2;
    axiWrite(8'h14, 32'h0000ab12, 2'h0);
    ws = 4'hf;
    axiRead(8'h14, 1, 32'h0000ab00, 2'h0);
    for (int code = 0; code < 5; code++) begin
      phyS = 5'($urandom);
      regS = 5'($urandom);
      d = 16'($urandom);
      wr = code[0];
      e = wr ? d : {3'h5, phyS, regS, 3'h3};
      if (wr) axiWrite(8'h14, {16'h0, d}, 2'h0);
      fq.push_back({wr ? 2'h1 : 2'h2, phyS, regS, e});
      axiWrite(8'h10, {16'h0, phyS, regS, 1'b0, code[2:0], wr, 1'b1}, 2'h0);
      axiWrite(8'h14, {16'h0, ~d}, 2'h0);
      do axiRead(8'h10, 0, 32'h0, 2'h0); while (rd[0] !== 1'b0);
      chk("mdc period", divTab[code], lastPer);
      axiRead(8'h14, 1, {16'h0, e}, 2'h0);
      axiRead(8'h10, 1, {16'h0, phyS, regS, 1'b0, code[2:0], wr, 1'b0}, 2'h0);
    end
    repeat (200) @(posedge clock);
    chk("frames left", 0, fq.size());
    chk("mdc idle", 0, mgmtPins.mdc);
    chk("oe idle", 0, mgmtPins.mdioOe);
    close_out();
  end
endmodule
